// ### mbsfc_codec.v
`timescale 1ns/1ps
`include "mbsfc_map.vh"

// Reply byte buffer with valid/ready on both sides
module mbsfc_fifo #(
  parameter W  = `MBSFC_FIFO_WIDTH,
  parameter D  = `MBSFC_FIFO_DEPTH,
  parameter AW = 5
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          nrst,
  // Fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // Drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg  [W-1:0] mem [0:D-1];  // Storage
  reg  [AW:0]  wp_q;         // Write pointer, wrap bit on top
  reg  [AW:0]  rp_q;         // Read pointer, wrap bit on top
  wire         full;
  wire         empty;

  assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty     = (wp_q == rp_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_q[AW-1:0]];

  // Storage write, no reset needed
  always @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // mbsfc_fifo

//Behaviour
// - Binary or text frame format selectable
// - Binary fields carry eight raw bits; code takes seven when cfg_eight is low
// - Text digits as upper-case character codes
// - Start, 7/8 data, parity option, stop
// - Binary frame preceded by 3.5-char silence
// - Address, function, data, then check word
// - 3.5-char silence ends binary frame
// - Gap over 1.5 chars restarts frame
// - Early new frame appends, check fails
// - Line watched except while driving; first byte is address
// - Addresses 0..247, zero is broadcast
// - Function 03H reads, 06H writes
// - Data carries words as byte pairs
// - CRC sent low byte then high
// - Text frame colon header, CR LF tail
// - Text bytes as two nibbles, high first
// - Text check byte before tail, high first
// - Text data at most sixteen bytes
// - Read asks one to five words
// - No reply to broadcast frames
// - Errored frames to this station, not broadcast, request an error reply
// - Half duplex, driver off while receiving
module mbsfc_codec #(
  parameter FW = `MBSFC_FIFO_WIDTH,
  parameter FD = `MBSFC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          nrst,
  // Bus line, driver enable high while driving
  input  wire          line_in,
  output wire          line_out,
  output wire          line_oe,
  // Configuration
  input  wire          cfg_ascii,
  input  wire          cfg_eight,
  input  wire          cfg_par_en,
  input  wire          cfg_par_odd,
  input  wire [7:0]    cfg_station,
  input  wire [15:0]   cfg_clk_per_bit,
  // Reply bytes and frame start
  input  wire          tx_valid,
  output wire          tx_ready,
  input  wire [FW-1:0] tx_data,
  input  wire          tx_go,
  output wire          tx_busy,
  // Received bytes
  output reg           rx_valid,
  output reg  [7:0]    rx_data,
  output reg           rx_first,
  // Frame verdict
  output reg           rx_done,
  output reg           rx_ok,
  output reg           rx_bcast,
  output reg           rx_read,
  output reg           rx_write,
  output reg           rx_err_reply
);
  // Transmit sequencer states
  localparam [7:0] T_IDLE = 8'h01, T_WAIT = 8'h02, T_HDR = 8'h04, T_DATA = 8'h08;
  localparam [7:0] T_CK = 8'h10, T_TL = 8'h20, T_FIN = 8'h40, T_DROP = 8'h80;

  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  b;
    integer      i;
    reg   [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `MBSFC_CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  function [7:0] hex_chr;
    input [3:0] n;
    begin
      if (n < 4'hA) begin
        hex_chr = `MBSFC_CH_0 + {4'h0, n};
      end else begin
        hex_chr = `MBSFC_CH_A + {4'h0, n} - `MBSFC_HEX_LETTER_OFS;
      end
    end
  endfunction

  wire [3:0]  dbits = cfg_eight ? 4'h8 : 4'h7;
  wire [3:0]  nbits = `MBSFC_START_STOP_BITS + dbits + {3'h0, cfg_par_en};
  wire [15:0] t_end = `MBSFC_SIL_END_HALVES * {12'h000, nbits};
  wire [15:0] t_gap = `MBSFC_SIL_GAP_HALVES * {12'h000, nbits};
  wire        tx_act;                         // Driver owns the line

  reg  [15:0] hb_cnt_q;
  wire        hb_tick = (hb_cnt_q == 16'h0000);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hb_cnt_q <= 16'h0000;
    end else if (hb_tick) begin
      hb_cnt_q <= {1'b0, cfg_clk_per_bit[15:1]} - 16'h0001;
    end else begin
      hb_cnt_q <= hb_cnt_q - 16'h0001;
    end
  end

  // Receiver character engine
  reg         rx_act_q;                       // Character in progress
  reg  [15:0] rx_div_q;                       // Bit timer
  reg  [3:0]  rx_idx_q;                       // Bit index, zero is start
  reg  [9:0]  rx_sh_q;                        // Data, parity, stop
  reg         line_q;                         // Line one cycle ago
  reg         chr_stb_q;                      // Character complete
  reg  [15:0] sil_q;                          // Idle half bits
  reg  [15:0] gap_q;                          // Idle before this character

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_act_q  <= 1'b0;
      rx_div_q  <= 16'h0000;
      rx_idx_q  <= 4'h0;
      rx_sh_q   <= 10'h000;
      line_q    <= 1'b1;
      chr_stb_q <= 1'b0;
      gap_q     <= 16'h0000;
    end else begin
      line_q    <= line_in;
      chr_stb_q <= 1'b0;
      if (!rx_act_q) begin
        if (line_q && !line_in && !tx_act) begin
          rx_act_q <= 1'b1;
          rx_div_q <= {1'b0, cfg_clk_per_bit[15:1]};
          rx_idx_q <= 4'h0;
          gap_q    <= sil_q;
        end
      end else if (rx_div_q != 16'h0000) begin
        rx_div_q <= rx_div_q - 16'h0001;
      end else begin
        rx_div_q <= cfg_clk_per_bit - 16'h0001;
        if (rx_idx_q == 4'h0) begin
          // False start if line high at mid start bit
          rx_act_q <= !line_in;
          rx_idx_q <= 4'h1;
        end else begin
          rx_sh_q[rx_idx_q - 4'h1] <= line_in;
          rx_idx_q <= rx_idx_q + 4'h1;
          if (rx_idx_q == nbits - 4'h1) begin
            rx_act_q  <= 1'b0;
            chr_stb_q <= 1'b1;
          end
        end
      end
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sil_q <= 16'h0000;
    end else if (rx_act_q || !line_in || tx_act) begin
      sil_q <= 16'h0000;
    end else if (hb_tick && sil_q != 16'hFFFF) begin
      sil_q <= sil_q + 16'h0001;
    end
  end

  // Character decode
  wire [7:0] chr   = cfg_eight ? rx_sh_q[7:0] : {1'b0, rx_sh_q[6:0]};
  wire       parb  = rx_sh_q[dbits];
  wire       stopb = rx_sh_q[nbits - 4'h2];
  wire       perr  = (cfg_par_en && ((^chr ^ parb) != cfg_par_odd)) || !stopb;
  wire       is_dig = (chr >= `MBSFC_CH_0) && (chr <= `MBSFC_CH_9);
  wire       is_let = (chr >= `MBSFC_CH_A) && (chr <= `MBSFC_CH_F);
  wire [7:0] nib8  = is_dig ? (chr - `MBSFC_CH_0) : (chr - `MBSFC_CH_A + `MBSFC_HEX_LETTER_OFS);

  // Frame assembly state
  reg        in_fr_q;                         // Frame open
  reg        err_q;                           // Character or coding fault
  reg        hi_q;                            // Text high nibble held
  reg  [3:0] hn_q;                            // Held high nibble
  reg        cr_q;                            // Text CR seen
  reg  [7:0] cnt_q;                           // Bytes in frame, saturating
  reg  [15:0] crc_q;
  reg  [7:0] lrc_q;
  reg  [7:0] addr_q;
  reg  [7:0] func_q;
  reg  [15:0] words_q;                        // Read word count

  // Byte strobe from either format
  wire       asc_hex = cfg_ascii && chr_stb_q && in_fr_q && !cr_q && chr != `MBSFC_CH_COLON && chr != `MBSFC_CH_CR;
  wire       b_stb  = cfg_ascii ? (asc_hex && hi_q && (is_dig || is_let)) : chr_stb_q;
  wire [7:0] b_val  = cfg_ascii ? {hn_q, nib8[3:0]} : chr;
  wire       b_first = cfg_ascii ? (cnt_q == 8'h00) : (!in_fr_q || gap_q > t_gap);
  wire       rtu_end = !cfg_ascii && in_fr_q && !rx_act_q && sil_q >= t_end;
  wire       asc_end = cfg_ascii && chr_stb_q && in_fr_q && cr_q;

  // Frame verdict terms
  wire       chk_ok = cfg_ascii ? (lrc_q == 8'h00) : (crc_q == 16'h0000);
  wire       len_ok = cfg_ascii ? (cnt_q >= `MBSFC_ASC_MIN_BYTES &&
                                   cnt_q - `MBSFC_ASC_MIN_BYTES <= `MBSFC_ASC_MAX_DATA)
                                : (cnt_q >= `MBSFC_RTU_MIN_BYTES);
  wire       bcast  = (addr_q == `MBSFC_ADDR_BCAST);
  wire       mine   = (addr_q <= `MBSFC_ADDR_MAX) && (bcast || addr_q == cfg_station);
  wire       fn_rd  = (func_q == `MBSFC_FN_READ);
  wire       fn_wr  = (func_q == `MBSFC_FN_WRITE);
  wire       cnt_ok = !fn_rd || (words_q != 16'h0000 && words_q <= `MBSFC_READ_MAX_WORDS);
  wire       good   = !err_q && chk_ok && len_ok && (fn_rd || fn_wr) && cnt_ok;

  // Frame assembly and verdict
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      in_fr_q  <= 1'b0;
      err_q    <= 1'b0;
      hi_q     <= 1'b0;
      hn_q     <= 4'h0;
      cr_q     <= 1'b0;
      cnt_q    <= 8'h00;
      crc_q    <= `MBSFC_CRC_INIT;
      lrc_q    <= 8'h00;
      addr_q   <= 8'h00;
      func_q   <= 8'h00;
      words_q  <= 16'h0000;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      rx_first <= 1'b0;
      rx_done  <= 1'b0;
      rx_ok    <= 1'b0;
      rx_bcast <= 1'b0;
      rx_read  <= 1'b0;
      rx_write <= 1'b0;
      rx_err_reply <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      rx_done  <= 1'b0;
      rx_err_reply <= 1'b0;
      if (cfg_ascii && chr_stb_q && chr == `MBSFC_CH_COLON) begin
        in_fr_q <= 1'b1;
        err_q   <= perr;
        hi_q    <= 1'b0;
        cr_q    <= 1'b0;
        cnt_q   <= 8'h00;
      end else if (cfg_ascii && chr_stb_q && in_fr_q) begin
        err_q <= err_q | perr;
        if (chr == `MBSFC_CH_CR && !cr_q) begin
          cr_q <= 1'b1;
          err_q <= err_q | perr | hi_q;
        end else if (asc_hex) begin
          hi_q <= !hi_q;
          hn_q <= nib8[3:0];
          if (!(is_dig || is_let)) begin
            err_q <= 1'b1;
          end
        end
      end
      if (b_stb) begin
        rx_valid <= 1'b1;
        rx_data  <= b_val;
        rx_first <= b_first;
        if (b_first) begin
          in_fr_q <= 1'b1;
          cnt_q   <= 8'h01;
          addr_q  <= b_val;
          crc_q   <= crc_step(`MBSFC_CRC_INIT, b_val);
          lrc_q   <= b_val;
          if (!cfg_ascii) begin
            err_q <= perr;
          end
        end else begin
          cnt_q <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
          crc_q <= crc_step(crc_q, b_val);
          lrc_q <= lrc_q + b_val;
          if (!cfg_ascii) begin
            err_q <= err_q | perr;
          end
          if (cnt_q == 8'h01) begin
            func_q <= b_val;
          end
          if (cnt_q == 8'h04) begin
            words_q[15:8] <= b_val;
          end
          if (cnt_q == 8'h05) begin
            words_q[7:0] <= b_val;
          end
        end
      end
      // frame closes on silence or on the character after CR
      if (rtu_end || asc_end) begin
        in_fr_q  <= 1'b0;
        cr_q     <= 1'b0;
        rx_done  <= 1'b1;
        rx_ok    <= mine && good && (!asc_end || chr == `MBSFC_CH_LF);
        rx_bcast <= bcast;
        rx_read  <= fn_rd;
        rx_write <= fn_wr;
        rx_err_reply <= mine && !bcast && !(good && (!asc_end || chr == `MBSFC_CH_LF));
      end
    end
  end

  // Reply buffer
  wire          f_valid;
  reg           f_pop;
  wire [FW-1:0] f_data;
  mbsfc_fifo #(.W(FW), .D(FD), .AW($clog2(FD))) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  // Transmit sequencer and character sender
  reg  [7:0]  ts_q;                           // Sequencer state
  reg         sub_q;                          // Nibble or byte half
  reg         blk_q;                          // Last frame was broadcast
  reg  [15:0] tcrc_q;
  reg  [7:0]  tlrc_q;
  reg         ld_q;                           // Character handed over
  reg  [7:0]  ch_q;                           // Character to send
  reg         snd_q;                          // Sender shifting
  reg  [10:0] sh_q;                           // Line bits, LSB first
  reg  [3:0]  left_q;                         // Bits still to send
  reg  [15:0] tdiv_q;
  wire        can = !snd_q && !ld_q;
  wire [7:0]  lrc_out = 8'h00 - tlrc_q;
  wire [7:0]  tb = f_data[7:0];

  assign tx_act   = (ts_q & (T_HDR | T_DATA | T_CK | T_TL | T_FIN)) != 8'h00;
  assign line_oe  = tx_act;
  assign line_out = snd_q ? sh_q[0] : 1'b1;
  assign tx_busy  = (ts_q != T_IDLE);

  // Buffer pop on byte hand-over or drop
  always @* begin
    f_pop = 1'b0;
    if (ts_q == T_DROP) begin
      f_pop = 1'b1;
    end else if (ts_q == T_DATA && can && f_valid && (!cfg_ascii || sub_q)) begin
      f_pop = 1'b1;
    end
  end

  // Sequencer
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ts_q   <= T_IDLE;
      sub_q  <= 1'b0;
      blk_q  <= 1'b0;
      tcrc_q <= `MBSFC_CRC_INIT;
      tlrc_q <= 8'h00;
      ld_q   <= 1'b0;
      ch_q   <= 8'h00;
    end else begin
      ld_q <= 1'b0;
      if (rx_done) begin
        blk_q <= rx_bcast;
      end
      case (ts_q)
        T_IDLE: begin
          sub_q  <= 1'b0;
          tcrc_q <= `MBSFC_CRC_INIT;
          tlrc_q <= 8'h00;
          if (tx_go) begin
            ts_q <= blk_q ? T_DROP : T_WAIT;
          end
        end
        T_WAIT: begin
          if ((cfg_ascii || sil_q >= t_end) && !in_fr_q && !rx_act_q) begin
            ts_q <= cfg_ascii ? T_HDR : T_DATA;
          end
        end
        T_HDR: begin
          if (can) begin
            ld_q <= 1'b1;
            ch_q <= `MBSFC_CH_COLON;
            ts_q <= T_DATA;
          end
        end
        T_DATA: begin
          if (can && !f_valid) begin
            ts_q  <= T_CK;
            sub_q <= 1'b0;
          end else if (can) begin
            ld_q <= 1'b1;
            if (!cfg_ascii) begin
              ch_q   <= tb;
              tcrc_q <= crc_step(tcrc_q, tb);
            end else begin
              ch_q  <= hex_chr(sub_q ? tb[3:0] : tb[7:4]);
              sub_q <= !sub_q;
              if (sub_q) begin
                tlrc_q <= tlrc_q + tb;
              end
            end
          end
        end
        T_CK: begin
          if (can) begin
            ld_q  <= 1'b1;
            sub_q <= !sub_q;
            if (!cfg_ascii) begin
              ch_q <= sub_q ? tcrc_q[15:8] : tcrc_q[7:0];
              if (sub_q) begin
                ts_q <= T_FIN;
              end
            end else begin
              ch_q <= hex_chr(sub_q ? lrc_out[3:0] : lrc_out[7:4]);
              if (sub_q) begin
                ts_q <= T_TL;
              end
            end
          end
        end
        T_TL: begin
          if (can) begin
            ld_q  <= 1'b1;
            ch_q  <= sub_q ? `MBSFC_CH_LF : `MBSFC_CH_CR;
            sub_q <= !sub_q;
            if (sub_q) begin
              ts_q <= T_FIN;
            end
          end
        end
        T_FIN: begin
          if (can) begin
            ts_q <= T_IDLE;
          end
        end
        T_DROP: begin
          if (!f_valid) begin
            ts_q <= T_IDLE;
          end
        end
        default: begin
          ts_q <= T_IDLE;
        end
      endcase
    end
  end

  wire [7:0] cd = cfg_eight ? ch_q : {1'b0, ch_q[6:0]};
  wire       tp = ^cd ^ cfg_par_odd;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      snd_q  <= 1'b0;
      sh_q   <= 11'h7FF;
      left_q <= 4'h0;
      tdiv_q <= 16'h0000;
    end else if (ld_q) begin
      snd_q  <= 1'b1;
      left_q <= nbits;
      tdiv_q <= cfg_clk_per_bit - 16'h0001;
      if (cfg_eight) begin
        sh_q <= {1'b0, cfg_par_en ? tp : 1'b1, cd, 1'b0} | (cfg_par_en ? 11'h400 : 11'h600);
      end else begin
        sh_q <= {2'b11, cfg_par_en ? tp : 1'b1, cd[6:0], 1'b0};
      end
    end else if (snd_q) begin
      if (tdiv_q != 16'h0000) begin
        tdiv_q <= tdiv_q - 16'h0001;
      end else begin
        tdiv_q <= cfg_clk_per_bit - 16'h0001;
        sh_q   <= {1'b1, sh_q[10:1]};
        left_q <= left_q - 4'h1;
        if (left_q == 4'h1) begin
          snd_q <= 1'b0;
        end
      end
    end
  end
endmodule // mbsfc_codec

// ### mbsfc_map.vh
`ifndef MBSFC_MAP_VH
`define MBSFC_MAP_VH
// Text-format framing and hex digit characters
`define MBSFC_CH_COLON 8'h3A
`define MBSFC_CH_CR 8'h0D
`define MBSFC_CH_LF 8'h0A
`define MBSFC_CH_0 8'h30
`define MBSFC_CH_9 8'h39
`define MBSFC_CH_A 8'h41
`define MBSFC_CH_F 8'h46
`define MBSFC_HEX_LETTER_OFS 8'h0A
// Function codes, address limits and count limits
`define MBSFC_FN_READ 8'h03
`define MBSFC_FN_WRITE 8'h06
`define MBSFC_ADDR_BCAST 8'h00
`define MBSFC_ADDR_MAX 8'hF7
`define MBSFC_READ_MAX_WORDS 16'h0005
`define MBSFC_ASC_MAX_DATA 8'h10
// Least bytes of a binary and of a text frame
`define MBSFC_RTU_MIN_BYTES 8'h04
`define MBSFC_ASC_MIN_BYTES 8'h03
// Check arithmetic
`define MBSFC_CRC_POLY 16'hA001
`define MBSFC_CRC_INIT 16'hFFFF
// Silence thresholds, in half characters
`define MBSFC_SIL_END_HALVES 16'h0007
`define MBSFC_SIL_GAP_HALVES 16'h0003
// Character layout
`define MBSFC_START_STOP_BITS 4'h2
// Reply buffer default shape
`define MBSFC_FIFO_WIDTH 8
`define MBSFC_FIFO_DEPTH 32
`endif

// ### mbsfc_codec_sva.sv
`timescale 1ns/1ps
// Boundary checks on the frame codec
module mbsfc_codec_sva (
  // Clock and reset
  input logic core_clk,
  input logic nrst,
  // Bus line
  input logic line_out,
  input logic line_oe,
  // Reply control
  input logic tx_go,
  input logic tx_busy,
  // Receive side
  input logic rx_valid,
  input logic rx_first,
  input logic rx_done,
  input logic rx_ok,
  input logic rx_bcast,
  input logic rx_read,
  input logic rx_write,
  input logic rx_err_reply
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Accepted reply launch
  sequence s_go;
    tx_go && !tx_busy;
  endsequence
  // Start bit soon after the driver turns on
  sequence s_start;
    ##[0:3] !line_out;
  endsequence
  property p_go; s_go |=> tx_busy; endproperty
  a_go: assert property (p_go) else $error("go not taken");
  property p_busy; $rose(tx_busy) |-> $past(tx_go); endproperty
  a_busy: assert property (p_busy) else $error("busy without go");
  property p_oe; line_oe |-> tx_busy; endproperty
  a_oe: assert property (p_oe) else $error("driver on while idle");
  property p_idle; !line_oe |-> line_out; endproperty
  a_idle: assert property (p_idle) else $error("line not idle high");
  property p_start; $rose(line_oe) |-> s_start; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_first; rx_first |-> rx_valid; endproperty
  a_first: assert property (p_first) else $error("address flag alone");
  property p_err; rx_err_reply |-> rx_done && !rx_bcast && !rx_ok; endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  property p_rw; rx_done && rx_ok |-> rx_read != rx_write; endproperty
  a_rw: assert property (p_rw) else $error("function decode");
  property p_bq; rx_bcast |-> !line_oe; endproperty
  a_bq: assert property (p_bq) else $error("reply to broadcast");
  property p_hold; !rx_done |-> $stable({rx_ok, rx_bcast, rx_read, rx_write}); endproperty
  a_hold: assert property (p_hold) else $error("verdict moved");
endmodule // mbsfc_codec_sva
bind mbsfc_codec mbsfc_codec_sva u_sva (.*);

// ### mbsfc_master.sv
`timescale 1ns/1ps
// Far-end master: character sender, reply listener
module mbsfc_master #(
  parameter int CPB = 8
) (
  // Clock and line
  input  wire logic core_clk,
  input  wire logic line_oe,
  input  wire logic line_out,
  output logic      drv
);
  logic [7:0] got[$]; // Reply bytes heard
  logic [7:0] sh;     // Receive shifter
  bit         par;    // Parity bit sent
  bit         odd;    // Odd parity sense
  bit         flip;   // Spoil the parity bit
  bit         seven;  // Seven data bits
  initial drv = 1'b1;
  // start, data LSB first, parity option, stop
  task send(input logic [7:0] b);
    logic [10:0] f;
    int          n;
    n = seven ? 7 : 8;
    f = {2'b11, b, 1'b0};
    if (seven) f[8] = 1'b1;
    if (par) f[n + 1] = ^b ^ odd ^ flip;
    for (int i = 0; i < n + 2 + par; i++) begin
      @(negedge core_clk) drv = f[i];
      repeat (CPB - 1) @(negedge core_clk);
    end
  endtask
  // listen only while the slave drives
  always begin
    @(negedge line_out iff line_oe);
    repeat (CPB / 2) @(posedge core_clk);
    for (int k = 0; k < 9; k++) begin
      repeat (CPB) @(posedge core_clk);
      if (k < 8) sh = {line_out, sh[7:1]};
    end
    got.push_back(sh);
  end
endmodule // mbsfc_master

// ### mbsfc_codec_bench.sv
`timescale 1ns/1ps
// Frame codec against a far-end master
module mbsfc_codec_bench;
  logic        core_clk = 0, nrst = 0, cfg_ascii = 0, tx_valid = 0, tx_go = 0;
  logic        cfg_eight = 1, cfg_par_en = 0, cfg_par_odd = 0, oe_seen;
  logic [15:0] cfg_clk_per_bit = 16'h0008;
  logic [7:0]  cfg_station = 8'h01, tx_data = 8'h00, fb;
  logic [7:0]  fr[$], ex[$], seen[$]; // Frame, expected, received
  logic [4:0]  vd;                    // ok, bcast, read, write, err
  wire  [7:0]  rx_data;
  wire         line_in, line_out, line_oe, tx_ready, tx_busy, rx_valid;
  wire         rx_first, rx_done, rx_ok, rx_bcast, rx_read, rx_write, rx_err_reply, drv;
  int          n_fail, compares, cyc, nd;
  // Whoever drives wins; else the master
  assign line_in = line_oe ? line_out : drv;
  mbsfc_codec dut (.*);
  mbsfc_master m (.*);
  initial forever #2.5 core_clk = ~core_clk;
  // Catch one-cycle pulses; cut hangs
  always @(posedge core_clk) begin
    if (rx_valid) seen.push_back(rx_data);
    if (rx_valid && rx_first) fb <= rx_data;
    if (rx_done) nd <= nd + 1;
    if (rx_done) vd <= {rx_ok, rx_bcast, rx_read, rx_write, rx_err_reply};
    if (line_oe) oe_seen <= 1'b1;
    if (++cyc == 30000) begin
      n_fail++;
      results;
    end
  end
  task chk(input logic [7:0] g, e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t: got %h want %h", $time, g, e);
    end
  endtask
  task results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] n, input bit lc);
    return n < 10 ? 8'h30 + n : (lc ? 8'h57 : 8'h37) + n;
  endfunction
  task rd;
    fr = {8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02};
  endtask
  task wait_v;
    repeat (900) @(negedge core_clk) if (nd != 0) break;
    chk(8'(nd), 8'h01);
  endtask
  // Binary frame plus check word
  task rtu(input bit bad, wt);
    logic [15:0] c;
    c = crc(fr) ^ 16'(bad);
    fr = {fr, c[7:0], c[15:8]};
    seen.delete();
    nd = 0;
    foreach (fr[i]) m.send(fr[i]);
    if (wt) wait_v;
  endtask
  // Text frame with check byte; lc spoils the case
  task asc(input bit lc);
    logic [7:0] s;
    s = 0;
    foreach (fr[i]) s -= fr[i];
    fr.push_back(s);
    nd = 0;
    m.send(8'h3A);
    foreach (fr[i]) begin
      m.send(hx(fr[i][7:4], lc));
      m.send(hx(fr[i][3:0], lc));
    end
    m.send(8'h0D);
    m.send(8'h0A);
    wait_v;
  endtask
  task push(input logic [7:0] b);
    @(negedge core_clk);
    tx_valid = 1;
    tx_data = b;
  endtask
  task go;
    @(negedge core_clk) tx_valid = 0;
    @(negedge core_clk) tx_go = 1;
    @(negedge core_clk) tx_go = 0;
    repeat (5000) @(negedge core_clk) if (!tx_busy) break;
    chk(tx_busy, 0);
  endtask
  task t_rtu_read;
    rd;
    rtu(0, 1);
    chk(vd, 5'h14);
    chk(fb, 8'h01);
    chk(seen[6], 8'h85);
    chk(seen[7], 8'hCA);
    $display("rtu read done");
  endtask
  // Faults, then the five-word edge
  task t_rtu_errs;
    for (int k = 0; k < 5; k++) begin
      fr = {8'h01, (k == 3) ? 8'h05 : 8'h03, 8'h00, 8'h04, 8'h00, (k == 1) ? 8'h06 : (k == 2) ? 8'h00 : 8'h05};
      rtu(k == 0, 1);
      chk({vd[4:3], vd[0]}, (k == 4) ? 8'h04 : 8'h01);
    end
    $display("rtu faults done");
  endtask
  // Long gap restarts; short gap appends
  task t_gap;
    m.send(8'h55);
    repeat (200) @(negedge core_clk);
    t_rtu_read;
    chk(vd[4], 1);
    rd;
    rtu(0, 0);
    rd;
    rtu(0, 1);
    chk(vd[4], 0);
    $display("gap done");
  endtask
  // Broadcast write, then own write
  task t_bcast;
    for (int a = 0; a < 2; a++) begin
      fr = {a[7:0], 8'h06, 8'h00, 8'h08, 8'h13, 8'h88};
      rtu(0, 1);
      chk(vd, a ? 5'h12 : 5'h1A);
      if (a == 0) begin
        for (int i = 0; i < 32; i++) push(i[7:0]);
        @(negedge core_clk) chk(tx_ready, 0);
        oe_seen = 0;
        go;
        chk(oe_seen, 0);
        chk(tx_ready, 1);
      end
    end
    $display("broadcast done");
  endtask
  // Reply in both formats
  task t_reply;
    logic [7:0]  s;
    logic [15:0] c;
    for (int a = 0; a < 2; a++) begin
      cfg_ascii = a[0];
      fr = {8'h01, 8'h03, 8'h02, 8'h13, 8'h8A};
      s = 0;
      ex = {};
      if (a) ex = {8'h3A};
      foreach (fr[i]) begin
        push(fr[i]);
        s -= fr[i];
        if (a) ex = {ex, hx(fr[i][7:4], 0), hx(fr[i][3:0], 0)};
        else ex.push_back(fr[i]);
      end
      c = crc(fr);
      if (a) ex = {ex, hx(s[7:4], 0), hx(s[3:0], 0), 8'h0D, 8'h0A};
      else ex = {ex, c[7:0], c[15:8]};
      m.got.delete();
      go;
      chk(8'(m.got.size()), 8'(ex.size()));
      foreach (ex[i]) chk(m.got[i], ex[i]);
    end
    $display("reply done");
  endtask
  // Text receive; lower case is a fault
  task t_ascii;
    cfg_ascii = 1;
    for (int k = 0; k < 2; k++) begin
      rd;
      asc(k[0]);
      chk({vd[4:3], vd[0]}, k ? 8'h01 : 8'h04);
    end
    $display("text done");
  endtask
  // Odd parity: clean, spoilt, then seven-bit text
  task t_parity;
    cfg_par_en = 1;
    cfg_par_odd = 1;
    m.par = 1;
    m.odd = 1;
    for (int k = 0; k < 3; k++) begin
      m.flip = (k == 1);
      m.seven = (k == 2);
      cfg_eight = (k != 2);
      cfg_ascii = (k == 2);
      rd;
      if (k == 2) asc(0);
      else rtu(0, 1);
      chk({vd[4:3], vd[0]}, (k == 1) ? 8'h01 : 8'h04);
    end
    $display("parity done");
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    nrst = 1;
    repeat (400) @(negedge core_clk);
    t_rtu_read;
    t_rtu_errs;
    t_gap;
    t_bcast;
    t_reply;
    t_ascii;
    t_parity;
    results;
  end
endmodule // mbsfc_codec_bench
